// file: hdl/sapa_pkg.sv
// Constants shared by the shared audio serial port: register map, fields, resets, rates.
//
// Summary of operation
// - Master drives clock and word select; slave receives.
// - I2S words 16 bits, frame 32, MSB aligned.
// - I2S MSB one bit clock after select change.
// - Left while select low, right while high.
// - Launch on falling edge; partner samples rising.
// - Master bit clock 1411.2 or 1536 kHz.
// - I2S half duplex; direction set by source bit.
// - I2S and PCM share hardware; one active.
// - PCM master makes clock and sync; slave receives.
// - PCM full duplex, 8 kHz frames; resets to I2S mode.
// - Up to three voice channels, sixteen slots.
// - Slot count follows rate, 1 to 16.
// - Transmit and receive share one slot.
// - Data pin released after last-bit falling edge.
// - Short sync: one-bit high pulse per frame.
// - Slave short sync: falling sample, next rise starts.
// - Long sync: three bits, starts with slot zero.
// - Short or long sync chosen by host.
// - Thirteen of sixteen bits used; fill programmable.
// - Default: 13-bit, left justified, zero fill, MSB first.
// - Burst mode on host command, up to 24 MHz.
package sapa_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned I2S_BCLK_44K_HZ = 1411200;
  localparam int unsigned I2S_BCLK_48K_HZ = 1536000;
  localparam int unsigned I2S_SLAVE_MAX_HZ = 3072000;
  localparam int unsigned PCM_BASE_HZ = 128000;
  localparam int unsigned BURST_MAX_HZ = 24000000;
  // Oscillator step per system clock: it wraps twice per bit clock period.
  localparam logic [63:0] INC_44K = 64'((64'(I2S_BCLK_44K_HZ) << 33) / 64'(CLK_HZ));
  localparam logic [63:0] INC_48K = 64'((64'(I2S_BCLK_48K_HZ) << 33) / 64'(CLK_HZ));
  localparam logic [63:0] INC_PCM = 64'((64'(PCM_BASE_HZ) << 33) / 64'(CLK_HZ));
  localparam logic [63:0] INC_BURST = 64'((64'(BURST_MAX_HZ) << 33) / 64'(CLK_HZ));
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_FMT = 12'h004;
  localparam logic [11:0] ADDR_SLOT = 12'h008;
  localparam logic [11:0] ADDR_BURST = 12'h00C;
  localparam logic [11:0] ADDR_STAT = 12'h010;
  localparam logic [11:0] ADDR_TX_BASE = 12'h020;
  localparam logic [11:0] ADDR_RX_BASE = 12'h030;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_PCM_BIT = 1;
  localparam int CTRL_MASTER_BIT = 2;
  localparam int CTRL_SRC_BIT = 3;
  localparam int CTRL_LONG_BIT = 4;
  localparam int CTRL_BURST_BIT = 5;
  localparam int CTRL_R48_BIT = 6;
  localparam int CTRL_SLOTS_LSB = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000077F;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam int FMT_FILL_LSB = 0;
  localparam int FMT_POS_LSB = 2;
  localparam int FMT_LSBF_BIT = 4;
  localparam int FMT_VAL_LSB = 5;
  localparam logic [31:0] FMT_MASK = 32'h000000FF;
  localparam logic [31:0] FMT_RST = 32'h0000000C;
  localparam int SLOT_STRIDE = 8;
  localparam int SLOT_EN_OFS = 4;
  localparam logic [31:0] SLOT_MASK = 32'h001F1F1F;
  localparam logic [31:0] SLOT_RST = 32'h00000010;
  localparam logic [31:0] BURST_RST = INC_BURST[31:0];
  localparam int STAT_I2S_BIT = 0;
  localparam int STAT_PCM_BIT = 1;
  localparam logic [15:0] SAMPLE_MASK = 16'h1FFF;
  localparam logic [7:0] LONG_SYNC_BITS = 8'h03;
  localparam logic [2:0] MAX_SLOTS_LOG = 3'h4;
  localparam logic [1:0] FILL_ZERO = 2'h0;
  localparam logic [1:0] FILL_ONE = 2'h1;
  localparam logic [1:0] FILL_SIGN = 2'h2;
endpackage : sapa_pkg

// file: hdl/sapa_port.sv
// Shared I2S / PCM audio serial port with an APB register slave.
`timescale 1ns/1ns
`default_nettype none
module sapa_port (
  input wire logic clk, // System clock, 50 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for an unmapped address.
  input wire logic sck_i, // Bit clock pin, input side.
  output logic sck_o, // Bit clock pin, output side.
  output logic sck_oe, // Bit clock pin driven by the port.
  input wire logic fs_i, // Word select or frame sync pin, input side.
  output logic fs_o, // Word select or frame sync pin, output side.
  output logic fs_oe, // Word select or frame sync pin driven.
  input wire logic sd_i, // Serial data in.
  output logic sd_o, // Serial data out.
  output logic sd_oe // Serial data out driven.
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] fmt;
    logic [31:0] slot;
    logic [31:0] burst;
    logic [1:0] stat;
    logic [2:0][31:0] tx;
    logic [2:0][31:0] rx;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic fs_s1;
    logic fs_s2;
    logic di_s1;
    logic di_s2;
    logic [31:0] acc;
    logic gen_sck;
    logic fs_o;
    logic sd_o;
    logic sd_oe;
    logic [4:0] cnt;
    logic ws_prev;
    logic load_nxt;
    logic rx_left;
    logic [3:0] rx_cnt;
    logic [15:0] sh;
    logic [15:0] rsh;
    logic [7:0] pcnt;
    logic arm0;
    logic arm1;
    logic fs_prev;
    logic pact;
    logic [1:0] pch;
  } sapa_state_s;

  sapa_state_s s_q;
  sapa_state_s s_d;

  ////////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] st, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (st[b])
      begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r & mask;
  endfunction : wmerge

  // Places a 13-bit sample at the chosen position and fills the three spare bits.
  function automatic logic [15:0] fmt_tx(input logic [12:0] smp, input logic [31:0] fmt);
    logic [15:0] m;
    logic [15:0] f;
    logic [1:0] k;
    m = sapa_pkg::SAMPLE_MASK << fmt[sapa_pkg::FMT_POS_LSB +: 2];
    f = 16'h0000;
    k = 2'h0;
    for (int i = 0; i < 16; i++)
    begin
      if (!m[i])
      begin
        unique case (fmt[sapa_pkg::FMT_FILL_LSB +: 2])
          sapa_pkg::FILL_ZERO: f[i] = 1'b0;
          sapa_pkg::FILL_ONE: f[i] = 1'b1;
          sapa_pkg::FILL_SIGN: f[i] = smp[12];
          default: f[i] = fmt[sapa_pkg::FMT_VAL_LSB + 32'(k)];
        endcase
        k = 2'(k + 2'h1);
      end
    end
    return (({3'h0, smp} << fmt[sapa_pkg::FMT_POS_LSB +: 2]) & m) | (f & ~m);
  endfunction : fmt_tx

  // Picks the 13 used bits out of a received word and sign-extends them; spares are ignored.
  function automatic logic [15:0] fmt_rx(input logic [15:0] w, input logic [31:0] fmt);
    logic [15:0] s;
    s = w >> fmt[sapa_pkg::FMT_POS_LSB +: 2];
    return {{3{s[12]}}, s[12:0]};
  endfunction : fmt_rx

  // Returns {hit, channel} for the first enabled channel mapped to a slot.
  function automatic logic [2:0] slot_hit(input logic [31:0] map, input logic [3:0] sl);
    logic [2:0] r;
    r = 3'h0;
    for (int c = 2; c >= 0; c--)
    begin
      if (map[c*sapa_pkg::SLOT_STRIDE + sapa_pkg::SLOT_EN_OFS] &&
          map[c*sapa_pkg::SLOT_STRIDE +: 4] == sl)
      begin
        r = {1'b1, 2'(c)};
      end
    end
    return r;
  endfunction : slot_hit

  ////////////////////////////////////////////////////////////////////////////////////////////
  logic en;
  logic pcm;
  logic master;
  logic src;
  logic lsbf;
  logic [2:0] slog;
  logic [7:0] pmask;
  logic [31:0] inc;
  logic [32:0] acc_sum;
  logic tgl;
  logic rise;
  logic fall;
  logic [4:0] cnt_n;
  logic ws_now;
  logic [15:0] word;
  logic [7:0] pn;
  logic [2:0] hit;
  logic [15:0] rword;
  logic [31:0] rd;
  logic rd_ok;
  logic [1:0] idx;
  logic setup_acc;

  always_comb
  begin
    s_d = s_q;
    en = s_q.ctrl[sapa_pkg::CTRL_EN_BIT];
    pcm = s_q.ctrl[sapa_pkg::CTRL_PCM_BIT];
    master = s_q.ctrl[sapa_pkg::CTRL_MASTER_BIT];
    src = s_q.ctrl[sapa_pkg::CTRL_SRC_BIT];
    lsbf = s_q.fmt[sapa_pkg::FMT_LSBF_BIT];
    slog = s_q.ctrl[sapa_pkg::CTRL_SLOTS_LSB +: 3];
    if (slog > sapa_pkg::MAX_SLOTS_LOG)
    begin
      slog = sapa_pkg::MAX_SLOTS_LOG;
    end
    pmask = 8'((16'h0010 << slog) - 16'h0001);
    cnt_n = 5'(s_q.cnt + 5'h01);
    word = 16'h0000;
    pn = 8'h00;
    hit = 3'h0;
    rword = 16'h0000;
    ws_now = 1'b0;
    idx = paddr[3:2];
    setup_acc = psel & penable & ~s_q.pready;

    // Register slave: one wait state, data and error prepared in the first access cycle.
    rd = 32'h00000000;
    rd_ok = (paddr[1:0] == 2'h0);
    unique case ({paddr[11:4], 4'h0})
      sapa_pkg::ADDR_CTRL:
      begin
        unique case (paddr[3:2])
          2'h0: rd = s_q.ctrl;
          2'h1: rd = s_q.fmt;
          2'h2: rd = s_q.slot;
          default: rd = s_q.burst;
        endcase
      end
      sapa_pkg::ADDR_STAT:
      begin
        rd = {22'h000000, s_q.pcnt, s_q.stat};
        rd_ok = rd_ok && (paddr[3:2] == 2'h0);
      end
      sapa_pkg::ADDR_TX_BASE:
      begin
        rd = s_q.tx[idx];
        rd_ok = rd_ok && (idx != 2'h3);
      end
      sapa_pkg::ADDR_RX_BASE:
      begin
        rd = s_q.rx[idx];
        rd_ok = rd_ok && (idx != 2'h3);
      end
      default: rd_ok = 1'b0;
    endcase
    s_d.pready = setup_acc;
    if (setup_acc)
    begin
      s_d.prdata = rd_ok ? rd : 32'h00000000;
      s_d.pslverr = ~rd_ok;
    end
    if (psel && penable && s_q.pready && pwrite && !s_q.pslverr)
    begin
      unique case ({paddr[11:2], 2'h0})
        sapa_pkg::ADDR_CTRL:
          s_d.ctrl = wmerge(s_q.ctrl, pwdata, pstrb, sapa_pkg::CTRL_MASK);
        sapa_pkg::ADDR_FMT: s_d.fmt = wmerge(s_q.fmt, pwdata, pstrb, sapa_pkg::FMT_MASK);
        sapa_pkg::ADDR_SLOT: s_d.slot = wmerge(s_q.slot, pwdata, pstrb, sapa_pkg::SLOT_MASK);
        sapa_pkg::ADDR_BURST: s_d.burst = wmerge(s_q.burst, pwdata, pstrb, 32'hFFFFFFFF);
        sapa_pkg::ADDR_STAT: s_d.stat = s_q.stat & ~(pwdata[1:0] & {2{pstrb[0]}});
        default:
        begin
          if (paddr[11:4] == sapa_pkg::ADDR_TX_BASE[11:4])
          begin
            s_d.tx[idx] = wmerge(s_q.tx[idx], pwdata, pstrb, 32'hFFFFFFFF);
          end
        end
      endcase
    end

    // Pin inputs pass two flops; the third stage only serves edge detection.
    s_d.sck_s1 = sck_i;
    s_d.sck_s2 = s_q.sck_s1;
    s_d.sck_s3 = s_q.sck_s2;
    s_d.fs_s1 = fs_i;
    s_d.fs_s2 = s_q.fs_s1;
    s_d.di_s1 = sd_i;
    s_d.di_s2 = s_q.di_s1;

    // Fractional oscillator; rates are exact on average, with one system clock of jitter.
    if (pcm)
    begin
      inc = s_q.ctrl[sapa_pkg::CTRL_BURST_BIT] ? s_q.burst :
            (sapa_pkg::INC_PCM[31:0] << slog);
    end
    else
    begin
      inc = s_q.ctrl[sapa_pkg::CTRL_R48_BIT] ? sapa_pkg::INC_48K[31:0] :
            sapa_pkg::INC_44K[31:0];
    end
    acc_sum = {1'b0, s_q.acc} + {1'b0, inc};
    tgl = en & master & acc_sum[32];
    s_d.acc = (en & master) ? acc_sum[31:0] : 32'h00000000;
    if (tgl)
    begin
      s_d.gen_sck = ~s_q.gen_sck;
    end
    // A slave takes any partner clock well below a quarter of the system clock.
    rise = en & (master ? (tgl & ~s_q.gen_sck) : (s_q.sck_s2 & ~s_q.sck_s3));
    fall = en & (master ? (tgl & s_q.gen_sck) : (~s_q.sck_s2 & s_q.sck_s3));

    if (!en)
    begin
      s_d.gen_sck = 1'b0;
      s_d.fs_o = 1'b0;
      s_d.sd_o = 1'b0;
      s_d.sd_oe = 1'b0;
      s_d.cnt = 5'h00;
      s_d.ws_prev = 1'b0;
      s_d.load_nxt = 1'b0;
      s_d.pcnt = 8'h00;
      s_d.pact = 1'b0;
      s_d.arm0 = 1'b0;
      s_d.arm1 = 1'b0;
    end
    else if (!pcm)
    begin
      ////////////////////////////////////////////////////////////////////////////////////////
      s_d.sd_oe = 1'b1;
      // A sink drops its data line at once, not only at the next bit clock fall.
      s_d.sd_o = src & s_q.sd_o;
      if (fall)
      begin
        if (master)
        begin
          s_d.cnt = cnt_n;
          s_d.fs_o = cnt_n[4];
        end
        ws_now = master ? cnt_n[4] : s_q.fs_s2;
        if (s_q.load_nxt)
        begin
          word = ws_now ? s_q.tx[0][15:0] : s_q.tx[0][31:16];
          s_d.sh = word;
          s_d.sd_o = src & word[15];
          s_d.rx_left = ~ws_now;
          s_d.rx_cnt = 4'h0;
        end
        else
        begin
          s_d.sh = s_q.sh << 1;
          s_d.sd_o = src & s_q.sh[14];
        end
        s_d.load_nxt = (ws_now != s_q.ws_prev);
        s_d.ws_prev = ws_now;
      end
      if (rise)
      begin
        s_d.rsh = {s_q.rsh[14:0], s_q.di_s2};
        s_d.rx_cnt = 4'(s_q.rx_cnt + 4'h1);
        if (s_q.rx_cnt == 4'hF)
        begin
          if (!src)
          begin
            if (s_q.rx_left)
            begin
              s_d.rx[0][31:16] = {s_q.rsh[14:0], s_q.di_s2};
            end
            else
            begin
              s_d.rx[0][15:0] = {s_q.rsh[14:0], s_q.di_s2};
            end
          end
          if (!s_q.rx_left)
          begin
            s_d.stat[sapa_pkg::STAT_I2S_BIT] = 1'b1;
          end
        end
      end
    end
    else
    begin
      ////////////////////////////////////////////////////////////////////////////////////////
      // An enable left over from stereo mode is dropped outside an active slot.
      s_d.sd_oe = s_q.sd_oe & s_q.pact;
      if (rise)
      begin
        if (!master && s_q.arm0)
        begin
          pn = 8'h00;
        end
        else if (!master && s_q.arm1)
        begin
          pn = 8'h01;
        end
        else
        begin
          pn = 8'(s_q.pcnt + 8'h01) & pmask;
        end
        s_d.pcnt = pn;
        s_d.arm0 = 1'b0;
        s_d.arm1 = 1'b0;
        if (master)
        begin
          s_d.fs_o = s_q.ctrl[sapa_pkg::CTRL_LONG_BIT] ?
                     (pn < sapa_pkg::LONG_SYNC_BITS) : (pn == pmask);
        end
        hit = slot_hit(s_q.slot, pn[7:4]);
        if (pn[3:0] == 4'h0 && hit[2])
        begin
          word = fmt_tx(s_q.tx[hit[1:0]][12:0], s_q.fmt);
          s_d.sh = word;
          s_d.pact = 1'b1;
          s_d.pch = hit[1:0];
          s_d.sd_oe = 1'b1;
          s_d.sd_o = lsbf ? word[0] : word[15];
        end
        else if (s_q.pact)
        begin
          s_d.sd_o = lsbf ? s_q.sh[pn[3:0]] : s_q.sh[4'hF - pn[3:0]];
        end
      end
      if (fall)
      begin
        s_d.fs_prev = s_q.fs_s2;
        s_d.arm0 = ~s_q.ctrl[sapa_pkg::CTRL_LONG_BIT] & s_q.fs_s2;
        s_d.arm1 = s_q.ctrl[sapa_pkg::CTRL_LONG_BIT] & s_q.fs_s2 & ~s_q.fs_prev;
        if (s_q.pact)
        begin
          s_d.rsh = {s_q.rsh[14:0], s_q.di_s2};
          if (s_q.pcnt[3:0] == 4'hF)
          begin
            rword = {s_q.rsh[14:0], s_q.di_s2};
            if (lsbf)
            begin
              rword = {<<{rword}};
            end
            s_d.rx[s_q.pch] = {16'h0000, fmt_rx(rword, s_q.fmt)};
            s_d.pact = 1'b0;
            s_d.sd_oe = 1'b0;
          end
        end
        if (s_q.pcnt == pmask)
        begin
          s_d.stat[sapa_pkg::STAT_PCM_BIT] = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
      s_q.ctrl <= sapa_pkg::CTRL_RST;
      s_q.fmt <= sapa_pkg::FMT_RST;
      s_q.slot <= sapa_pkg::SLOT_RST;
      s_q.burst <= sapa_pkg::BURST_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pready & s_q.pslverr;
  assign sck_o = s_q.gen_sck;
  assign sck_oe = en & master;
  assign fs_o = s_q.fs_o;
  assign fs_oe = en & master;
  assign sd_o = s_q.sd_o;
  assign sd_oe = s_q.sd_oe;

endmodule : sapa_port
`default_nettype wire

// file: tb/sapa_port_sva.sv
// Concurrent checks on the audio port pins and its register bus.
`timescale 1ns/1ns
`default_nettype none
module sapa_port_sva (
  input wire logic clk, // System clock.
  input wire logic arst_n, // Reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB strobes.
  input wire logic pready, // APB ready.
  input wire logic pslverr, // APB error.
  input wire logic sck_o, // Bit clock out.
  input wire logic sck_oe, // Bit clock driven.
  input wire logic fs_o, // Select or sync out.
  input wire logic fs_oe, // Select or sync driven.
  input wire logic sd_o, // Data out.
  input wire logic sd_oe // Data driven.
);
  // A shadow of the control byte tells the pin checks the mode; a settle
  // count keeps them quiet while the port switches modes.
  logic [7:0] ctl_q;
  logic [7:0] ctl_d;
  logic [1:0] age_q;
  logic calm;
  logic i2s_m;
  logic pcm_m;
  always_comb
  begin
    ctl_d = ctl_q;
    if (psel && penable && pready && pwrite && paddr == sapa_pkg::ADDR_CTRL && pstrb[0])
      ctl_d = pwdata[7:0];
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctl_q <= 8'h00;
      age_q <= 2'h0;
    end
    else
    begin
      ctl_q <= ctl_d;
      age_q <= (ctl_d != ctl_q) ? 2'h0 : ((age_q == 2'h3) ? 2'h3 : age_q + 2'h1);
    end
  end
  assign calm = (age_q == 2'h3);
  assign i2s_m = calm && ctl_q[0] && !ctl_q[1] && ctl_q[2];
  assign pcm_m = calm && ctl_q[0] && ctl_q[1] && ctl_q[2];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence apb_access;
    psel && !penable ##1 psel && penable;
  endsequence
  a_rdy_one_wait: assert property (apb_access |=> pready)
    else $error("ready not one cycle into access");
  a_rdy_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_rdy: assert property (pready && (paddr[1:0] != 2'h0 || paddr[11:6] != 6'h00)
    |-> pslverr) else $error("refused address answered without error");
  a_oe_by_role: assert property (sck_oe == (ctl_q[0] && ctl_q[2]) && fs_oe == sck_oe)
    else $error("clock and sync enables do not follow role");
  a_off_quiet: assert property (calm && !ctl_q[0] |-> !sd_oe && !sck_oe)
    else $error("pins driven while disabled");
  a_i2s_drives: assert property (calm && ctl_q[0] && !ctl_q[1] |-> sd_oe)
    else $error("data out not driven in stereo mode");
  a_sink_quiet: assert property (calm && ctl_q[0] && !ctl_q[1] && !ctl_q[3] |-> !sd_o)
    else $error("data sent while sink");
  a_ws_on_fall: assert property (i2s_m && $changed(fs_o) |-> !sck_o && $fell(sck_o))
    else $error("word select changed off a falling bit clock");
  a_sd_on_fall: assert property (i2s_m && ctl_q[3] && $changed(sd_o) |-> !sck_o)
    else $error("stereo data changed while bit clock high");
  a_sync_on_rise: assert property (pcm_m && $changed(fs_o) |-> sck_o)
    else $error("frame sync changed while bit clock low");
  a_oe_on_rise: assert property (pcm_m && $rose(sd_oe) |-> sck_o)
    else $error("voice slot driven before rising edge");
  a_oe_release: assert property (pcm_m && $fell(sd_oe) |-> !sck_o)
    else $error("voice slot released before falling edge");
endmodule : sapa_port_sva
bind sapa_port sapa_port_sva i_sva (.clk(clk), .arst_n(arst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .sck_o(sck_o), .sck_oe(sck_oe), .fs_o(fs_o),
  .fs_oe(fs_oe), .sd_o(sd_o), .sd_oe(sd_oe));
`default_nettype wire

// file: tb/sapa_codec.sv
// Behavioural model of the external codec on the audio link.
`timescale 1ns/1ns
`default_nettype none
module sapa_codec (
  input wire logic gen, // Model makes bit clock and word select.
  input wire logic pcm, // Voice framing instead of stereo framing.
  input wire logic [31:0] tx_frame, // Stereo frame sent, left word high.
  input wire logic [15:0] tx_voice, // Voice word sent.
  input wire logic sck, // Bit clock at the pin.
  input wire logic fs, // Select or sync at the pin.
  input wire logic sd, // Data from the port.
  output logic sck_p, // Bit clock when generating.
  output logic fs_p, // Word select when generating.
  output logic sd_p, // Data towards the port.
  output logic [15:0] left_q, // Last left word received.
  output logic [15:0] right_q, // Last right word received.
  output logic [15:0] voice_q, // Last voice word received.
  output int n_words // Words received so far.
);
  logic [15:0] sh = 16'h0000;
  logic [4:0] bit_n = 5'h00;
  logic [3:0] idx = 4'h0;
  logic ws_last = 1'b0;
  initial
  begin
    sck_p = 1'b0;
    fs_p = 1'b0;
    sd_p = 1'b0;
    n_words = 0;
    // The odd offset keeps link edges clear of the system clock edges.
    #7;
    forever
    begin
      #80;
      // The clock parks low once generation stops.
      if (gen || sck_p)
        sck_p = ~sck_p;
    end
  end
  always @(posedge sck)
  begin
    if (pcm)
      sd_p = tx_voice[4'hF - idx];
    else
    begin
      sh = {sh[14:0], sd};
      if (fs != ws_last)
      begin
        if (ws_last)
          right_q = sh;
        else
          left_q = sh;
        n_words++;
      end
      ws_last = fs;
    end
  end
  always @(negedge sck)
  begin
    if (pcm)
    begin
      sh = {sh[14:0], sd};
      if (fs)
      begin
        voice_q = sh;
        n_words++;
        idx = 4'h0;
      end
      else
        idx = idx + 4'h1;
    end
    else if (gen)
    begin
      bit_n = bit_n + 5'h01;
      fs_p = bit_n[4];
      sd_p = tx_frame[5'd31 - (bit_n - 5'd1)];
    end
    else
      sd_p = ~sd_p;
  end
endmodule : sapa_codec
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the shared audio serial port.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sck_o, sck_oe, fs_o, fs_oe, sd_o, sd_oe;
  logic sck_p, fs_p, sd_p;
  logic gen = 1'b0;
  logic pcm = 1'b0;
  logic sd_q = 1'b0;
  logic [15:0] left_q, right_q, voice_q;
  int n_words;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  wire logic sck_w = sck_oe ? sck_o : sck_p;
  wire logic fs_w = fs_oe ? fs_o : fs_p;
  always #10 clk = ~clk;
  // Data seen by the codec lags one cycle, so the bit on the line just
  // before a release edge is the one sampled; a released line toggles.
  always @(posedge clk)
    sd_q <= sd_oe ? sd_o : ~sd_q;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      complete_run();
    end
  end
  sapa_port i_sapa_port (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe),
    .fs_i(fs_w), .fs_o(fs_o), .fs_oe(fs_oe), .sd_i(sd_p), .sd_o(sd_o), .sd_oe(sd_oe));
  sapa_codec i_sapa_codec (.gen(gen), .pcm(pcm), .tx_frame(32'h3C5AC001),
    .tx_voice(16'h9876), .sck(sck_w), .fs(fs_w), .sd(sd_q), .sck_p(sck_p), .fs_p(fs_p),
    .sd_p(sd_p), .left_q(left_q), .right_q(right_q), .voice_q(voice_q), .n_words(n_words));
  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic rng(input string name, input int c, input int lo, input int hi);
    chk(name, {31'h0, c >= lo && c <= hi}, 32'h1);
  endtask : rng
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    pstrb <= 4'hF;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] x,
    input logic ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(n, r, x);
    chk({n, " err"}, {31'h0, e}, {31'h0, ex});
  endtask : rdc
  task automatic meas(input int n, output int c);
    int c0;
    @(posedge sck_o);
    c0 = cyc;
    repeat (n) @(posedge sck_o);
    c = cyc - c0;
  endtask : meas
  task automatic wait_words(input int n);
    int k;
    k = n_words;
    wait (n_words >= k + n);
  endtask : wait_words
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rdc("ctrl", sapa_pkg::ADDR_CTRL, sapa_pkg::CTRL_RST, 1'b0);
    rdc("fmt", sapa_pkg::ADDR_FMT, sapa_pkg::FMT_RST, 1'b0);
    rdc("slot", sapa_pkg::ADDR_SLOT, sapa_pkg::SLOT_RST, 1'b0);
    rdc("burst", sapa_pkg::ADDR_BURST, sapa_pkg::BURST_RST, 1'b0);
    wr(12'h0FC, 32'hFFFFFFFF);
    rdc("hole", 12'h0FC, 32'h00000000, 1'b1);
    rdc("misaligned", 12'h002, 32'h00000000, 1'b1);
    wr(sapa_pkg::ADDR_FMT, 32'hFFFFFFFF);
    rdc("fmt rw", sapa_pkg::ADDR_FMT, sapa_pkg::FMT_MASK, 1'b0);
    wr(sapa_pkg::ADDR_FMT, sapa_pkg::FMT_RST);
  endtask : t_regs
  task automatic t_i2s_master();
    int c;
    int c0;
    wr(sapa_pkg::ADDR_TX_BASE, 32'hA5C31234);
    wr(sapa_pkg::ADDR_CTRL, 32'h0000000D);
    wait_words(6);
    chk("left", {16'h0000, left_q}, 32'h0000A5C3);
    chk("right", {16'h0000, right_q}, 32'h00001234);
    chk("master oe", {31'h0, sck_oe}, 32'h1);
    meas(32, c);
    rng("rate 44k", c, 1132, 1136);
    @(fs_o);
    c0 = cyc;
    @(fs_o);
    rng("ws half", cyc - c0, 565, 569);
    wr(sapa_pkg::ADDR_CTRL, 32'h0000004D);
    meas(32, c);
    rng("rate 48k", c, 1040, 1043);
  endtask : t_i2s_master
  task automatic t_i2s_slave();
    wr(sapa_pkg::ADDR_CTRL, 32'h00000001);
    gen <= 1'b1;
    wait_words(8);
    gen <= 1'b0;
    chk("slave oe", {31'h0, sck_oe}, 32'h0);
    rdc("rx frame", sapa_pkg::ADDR_RX_BASE, 32'h3C5AC001, 1'b0);
  endtask : t_i2s_slave
  task automatic t_pcm();
    logic [7:0] fmts [4] = '{8'h0C, 8'h0D, 8'h0E, 8'hAF};
    logic [15:0] exps [4] = '{16'hD5E0, 16'hD5E7, 16'hD5E7, 16'hD5E5};
    logic [31:0] r;
    logic e;
    int c;
    int c0;
    pcm <= 1'b1;
    wr(sapa_pkg::ADDR_TX_BASE, 32'h00001ABC);
    wr(sapa_pkg::ADDR_BURST, 32'h10000000);
    wr(sapa_pkg::ADDR_CTRL, 32'h00000027);
    for (int i = 0; i < 4; i++)
    begin
      wr(sapa_pkg::ADDR_FMT, {24'h000000, fmts[i]});
      wait_words(2);
      chk("voice out", {16'h0000, voice_q}, {16'h0000, exps[i]});
    end
    apb(1'b0, sapa_pkg::ADDR_RX_BASE, 32'h00000000, r, e);
    chk("voice in", {16'h0000, r[15:0]}, 32'h0000F30E);
    meas(16, c);
    rng("burst rate", c, 511, 513);
    wr(sapa_pkg::ADDR_CTRL, 32'h00000037);
    // The first pulse after the switch may be cut short, so it is skipped.
    @(negedge fs_o);
    @(posedge fs_o);
    c0 = cyc;
    @(negedge fs_o);
    rng("long sync", cyc - c0, 95, 97);
    wr(sapa_pkg::ADDR_CTRL, 32'h00000007);
    meas(16, c);
    rng("voice rate", c, 6248, 6252);
  endtask : t_pcm
  initial
  begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_regs();
    t_i2s_master();
    t_i2s_slave();
    t_pcm();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
